/* File: rtl/asq_regs.svh */
// Constants of the scan sequencer: channel limits, codes and timing counts
`ifndef ASQ_REGS_SVH
`define ASQ_REGS_SVH

// ****************************************
// Bus address and data format
// ****************************************
// Address value is arbitrary
`define ASQ_SLAVE_ADDR      7'h2a
`define ASQ_RES_W           12
`define ASQ_MEM_DEPTH       12
`define ASQ_FILLER          4'hf
`define ASQ_REPEAT_COUNT    4'h8

// ****************************************
// Channel limits
// ****************************************
`define ASQ_CH_MAX_4        4'h3
`define ASQ_CH_MAX_4_REF    4'h2
`define ASQ_CH_MAX_8        4'h7
`define ASQ_CH_MAX_12       4'hb
`define ASQ_CH_MAX_12_REF   4'ha
`define ASQ_UPPER_FIRST_4   4'h2
`define ASQ_UPPER_FIRST_8   4'h6
`define ASQ_CS_LAST_VALID   4'hb

// ****************************************
// Reference source codes
// ****************************************
`define ASQ_REF_SUPPLY      2'h0
`define ASQ_REF_EXTERNAL    2'h1
`define ASQ_REF_INTERNAL    2'h2

// ****************************************
// Timing
// ****************************************
`define ASQ_CLK_PERIOD_NS   5.0
`define ASQ_CONV_TIME_US    8.3
`define ASQ_CONV_CYCLES     ($rtoi(`ASQ_CONV_TIME_US * 1000.0 / `ASQ_CLK_PERIOD_NS))

`endif

/* File: rtl/asq_pkg.sv */
// Types of the scan sequencer
package asq_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b010,
    ST_CONV = 3'b011,
    ST_LOAD = 3'b100,
    ST_TX   = 3'b101,
    ST_MACK = 3'b110,
    ST_HOLD = 3'b111
  } asq_state_t;

  typedef enum logic [1:0] {
    SCAN_UP     = 2'b00,
    SCAN_REPEAT = 2'b01,
    SCAN_UPPER  = 2'b10,
    SCAN_SINGLE = 2'b11
  } asq_scan_t;

  typedef enum logic [1:0] {
    VAR_4CH  = 2'b00,
    VAR_8CH  = 2'b01,
    VAR_12CH = 2'b10
  } asq_variant_t;

endpackage

/* File: rtl/asq_result_mem.sv */
// Result memory with registered read data
`timescale 1ns/100ps
`include "asq_regs.svh"
module asq_result_mem (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Write port
  input  wire logic        we_in,
  input  wire logic [3:0]  waddr_in,
  input  wire logic [11:0] wdata_in,
  // Read port
  input  wire logic        re_in,
  input  wire logic [3:0]  raddr_in,
  output logic      [11:0] rdata_out
);

  // Contents carry no reset, they are undefined after power-on
  logic [11:0] mem_q [`ASQ_MEM_DEPTH];

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem_q[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 12'h000;
    end else if (re_in) begin
      rdata_out <= mem_q[raddr_in];
    end
  end

endmodule

/* File: rtl/asq_top.sv */
// Scan sequencer with two-wire slave readout
`timescale 1ns/100ps
`include "asq_regs.svh"
module asq_top (
  // Clock and reset
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RST_N_IN,
  // Two-wire port
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  output logic             SCL_OUT,
  output logic             SCL_OE_OUT,
  output logic             SDA_OUT,
  output logic             SDA_OE_OUT,
  // Configuration
  input  wire logic        SCAN_MODE_HIGH_BIT_IN,
  input  wire logic        SCAN_MODE_LOW_BIT_IN,
  input  wire logic [3:0]  CHANNEL_SELECT_FIELD_IN,
  input  wire logic        EXT_CLOCK_MODE_IN,
  input  wire logic        REFERENCE_SOURCE_HIGH_BIT_IN,
  input  wire logic        SHARED_PIN_REFERENCE_BIT_IN,
  input  wire logic        INTERNAL_REFERENCE_KEEP_ON_BIT_IN,
  input  wire logic [1:0]  VARIANT_IN,
  // Converter
  output logic             CONV_START_OUT,
  output logic      [3:0]  CONV_CH_OUT,
  input  wire logic [11:0] ADC_RESULT_IN,
  // Power and reference
  output logic             ANALOG_PWR_OUT,
  output logic             REF_ON_OUT,
  output logic             REF_DRIVE_OUT,
  output logic      [1:0]  REF_SRC_OUT
);

  localparam int         CONV_CYC  = `ASQ_CONV_CYCLES;
  localparam logic [10:0] CONV_LAST = 11'(CONV_CYC - 1);

  // ****************************************
  // Pin synchronisers and bus conditions
  // ****************************************
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else begin
      scl_s1_q <= SCL_IN;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= SDA_IN;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  assign scl_rise  = scl_s2_q & ~scl_s3_q;
  assign scl_fall  = ~scl_s2_q & scl_s3_q;
  assign bus_start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  assign bus_stop  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

  // ****************************************
  // Scan range decode
  // ****************************************
  asq_pkg::asq_state_t state_q;
  asq_pkg::asq_scan_t  scan_mode;
  logic [3:0] cs_eff, max_ch, upper_first, lim_ch, first_ch, last_ch, n_conv;
  logic       scan_ok;

  assign scan_mode = asq_pkg::asq_scan_t'({SCAN_MODE_HIGH_BIT_IN, SCAN_MODE_LOW_BIT_IN});

  always_comb begin
    case (asq_pkg::asq_variant_t'(VARIANT_IN))
      asq_pkg::VAR_4CH: begin
        cs_eff      = {2'b00, CHANNEL_SELECT_FIELD_IN[1:0]};
        max_ch      = SHARED_PIN_REFERENCE_BIT_IN ? `ASQ_CH_MAX_4_REF : `ASQ_CH_MAX_4;
        upper_first = `ASQ_UPPER_FIRST_4;
      end
      asq_pkg::VAR_8CH: begin
        cs_eff      = {1'b0, CHANNEL_SELECT_FIELD_IN[2:0]};
        max_ch      = `ASQ_CH_MAX_8;
        upper_first = `ASQ_UPPER_FIRST_8;
      end
      default: begin
        cs_eff      = CHANNEL_SELECT_FIELD_IN;
        max_ch      = SHARED_PIN_REFERENCE_BIT_IN ? `ASQ_CH_MAX_12_REF : `ASQ_CH_MAX_12;
        upper_first = `ASQ_UPPER_FIRST_8;
      end
    endcase
    lim_ch = (cs_eff > max_ch) ? max_ch : cs_eff;
    case (scan_mode)
      asq_pkg::SCAN_UP: begin
        first_ch = 4'h0;
        last_ch  = lim_ch;
        scan_ok  = 1'b1;
      end
      asq_pkg::SCAN_UPPER: begin
        first_ch = upper_first;
        last_ch  = (lim_ch < upper_first) ? upper_first : lim_ch;
        scan_ok  = 1'b1;
      end
      default: begin
        first_ch = cs_eff;
        last_ch  = cs_eff;
        scan_ok  = (cs_eff <= `ASQ_CS_LAST_VALID);
      end
    endcase
    if (!scan_ok) begin
      n_conv = 4'h0;
    end else if (scan_mode == asq_pkg::SCAN_REPEAT) begin
      n_conv = `ASQ_REPEAT_COUNT;
    end else if (scan_mode == asq_pkg::SCAN_SINGLE) begin
      n_conv = 4'h1;
    end else begin
      n_conv = 4'(last_ch - first_ch + 4'h1);
    end
  end

  // ****************************************
  // Conversion sequencer
  // ****************************************
  logic        seq_start, active, readout, fill_ready, ext_push;
  logic        busy_q, done_q, start_q, ext_q, rep_q, ok_q;
  logic [10:0] cyc_q;
  logic [3:0]  ch_q, idx_q, first_q, last_q, n_res_q, next_ch;
  logic        mem_we;

  assign seq_start = (state_q == asq_pkg::ST_AACK) && scl_fall;
  assign active    = (state_q == asq_pkg::ST_CONV) || readout;
  assign readout   = (state_q == asq_pkg::ST_LOAD) || (state_q == asq_pkg::ST_TX) ||
                     (state_q == asq_pkg::ST_MACK);
  // A repeat mode stays on one channel, a scan wraps back to its first channel
  assign next_ch   = rep_q ? ch_q : ((ch_q == last_q) ? first_q : 4'(ch_q + 4'h1));
  // Clock-line edges finish each external conversion; in the load wait one may finish at once,
  // but only after its start has reached the converter, or a stale channel would be stored
  assign ext_push  = busy_q && ext_q && readout && fill_ready &&
                     (scl_fall || ((state_q == asq_pkg::ST_LOAD) && !start_q));
  assign mem_we    = busy_q && !ext_q && (state_q == asq_pkg::ST_CONV) && (cyc_q == CONV_LAST);

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      start_q <= 1'b0;
      cyc_q   <= 11'h000;
      ch_q    <= 4'h0;
      idx_q   <= 4'h0;
      ext_q   <= 1'b0;
      rep_q   <= 1'b1;
      ok_q    <= 1'b0;
      first_q <= 4'h0;
      last_q  <= 4'h0;
      n_res_q <= 4'h0;
    end else begin
      start_q <= 1'b0;
      done_q  <= 1'b0;
      if (seq_start) begin
        ext_q   <= EXT_CLOCK_MODE_IN;
        rep_q   <= scan_mode[0];
        ok_q    <= scan_ok;
        first_q <= first_ch;
        last_q  <= last_ch;
        n_res_q <= n_conv;
        ch_q    <= first_ch;
        cyc_q   <= 11'h000;
        idx_q   <= 4'h0;
        busy_q  <= scan_ok;
        start_q <= scan_ok;
        done_q  <= ~scan_ok;
      end else if (!active) begin
        busy_q <= 1'b0;
      end else if (busy_q && !ext_q) begin
        if (cyc_q == CONV_LAST) begin
          cyc_q <= 11'h000;
          idx_q <= 4'(idx_q + 4'h1);
          if (4'(idx_q + 4'h1) == n_res_q) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end else begin
            ch_q    <= next_ch;
            start_q <= 1'b1;
          end
        end else begin
          cyc_q <= 11'(cyc_q + 11'h001);
        end
      end else if (ext_push) begin
        ch_q    <= next_ch;
        start_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // Result memory and readout pointer
  // ****************************************
  logic        rd_issue, rd_pend_q;
  logic [3:0]  rd_ptr_q;
  logic [11:0] mem_rdata;
  logic [1:0]  buf_cnt_q;

  // Reads only follow the conversions of the current addressing
  assign rd_issue = readout && !ext_q && !rd_pend_q && (buf_cnt_q != 2'h2) && (n_res_q != 4'h0);

  asq_result_mem u_mem (
    .clk_in    (SYS_CLK_IN),
    .rst_n_in  (RST_N_IN),
    .we_in     (mem_we),
    .waddr_in  (idx_q),
    .wdata_in  (ADC_RESULT_IN),
    .re_in     (rd_issue),
    .raddr_in  (rd_ptr_q),
    .rdata_out (mem_rdata)
  );

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rd_ptr_q  <= 4'h0;
      rd_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= rd_issue;
      if (seq_start) begin
        rd_ptr_q <= 4'h0;
      end else if (rd_issue) begin
        rd_ptr_q <= (rd_ptr_q == 4'(n_res_q - 4'h1)) ? 4'h0 : 4'(rd_ptr_q + 4'h1);
      end
    end
  end

  // ****************************************
  // Two-entry result buffer
  // ****************************************
  // Holding the clock line low while empty stalls the master, so no word is lost
  logic [11:0] buf_q [2];
  logic        buf_wp_q, buf_rp_q, buf_push, buf_pop, byte_hi_q;
  logic [11:0] buf_wdata, buf_head;

  assign fill_ready = (buf_cnt_q != 2'h2);
  assign buf_push   = rd_pend_q || ext_push;
  assign buf_wdata  = ext_q ? ADC_RESULT_IN : mem_rdata;
  assign buf_head   = buf_q[buf_rp_q];
  assign buf_pop    = (state_q == asq_pkg::ST_LOAD) && byte_hi_q && (buf_cnt_q != 2'h0);

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      buf_q[0]  <= 12'h000;
      buf_q[1]  <= 12'h000;
      buf_wp_q  <= 1'b0;
      buf_rp_q  <= 1'b0;
      buf_cnt_q <= 2'h0;
    end else if (seq_start) begin
      buf_wp_q  <= 1'b0;
      buf_rp_q  <= 1'b0;
      buf_cnt_q <= 2'h0;
    end else begin
      if (buf_push) begin
        buf_q[buf_wp_q] <= buf_wdata;
        buf_wp_q        <= ~buf_wp_q;
      end
      if (buf_pop) begin
        buf_rp_q <= ~buf_rp_q;
      end
      case ({buf_push, buf_pop})
        2'b10:   buf_cnt_q <= 2'(buf_cnt_q + 2'h1);
        2'b01:   buf_cnt_q <= 2'(buf_cnt_q - 2'h1);
        default: buf_cnt_q <= buf_cnt_q;
      endcase
    end
  end

  // ****************************************
  // Slave protocol engine
  // ****************************************
  logic [7:0] sh_q, lo_q;
  logic [3:0] bit_cnt_q;
  logic       ack_q, sda_oe_q, scl_oe_q, data_ok;

  assign data_ok = ext_q ? ok_q : (n_res_q != 4'h0);

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_q   <= asq_pkg::ST_IDLE;
      sh_q      <= 8'h00;
      lo_q      <= 8'h00;
      bit_cnt_q <= 4'h0;
      byte_hi_q <= 1'b1;
      ack_q     <= 1'b0;
      sda_oe_q  <= 1'b0;
      scl_oe_q  <= 1'b0;
    end else if (bus_start) begin
      state_q   <= asq_pkg::ST_ADDR;
      bit_cnt_q <= 4'h0;
      sda_oe_q  <= 1'b0;
      scl_oe_q  <= 1'b0;
    end else if (bus_stop) begin
      state_q  <= asq_pkg::ST_IDLE;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
    end else begin
      case (state_q)
        asq_pkg::ST_ADDR: begin
          if (scl_rise) begin
            sh_q      <= {sh_q[6:0], sda_s2_q};
            bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
          end else if (scl_fall && (bit_cnt_q == 4'h8)) begin
            if ((sh_q[7:1] == `ASQ_SLAVE_ADDR) && sh_q[0]) begin
              state_q  <= asq_pkg::ST_AACK;
              sda_oe_q <= 1'b1;
            end else begin
              state_q <= asq_pkg::ST_IDLE;
            end
          end
        end
        asq_pkg::ST_AACK: begin
          if (scl_fall) begin
            sda_oe_q  <= 1'b0;
            scl_oe_q  <= 1'b1;
            byte_hi_q <= 1'b1;
            state_q   <= EXT_CLOCK_MODE_IN ? asq_pkg::ST_LOAD : asq_pkg::ST_CONV;
          end
        end
        asq_pkg::ST_CONV: begin
          if (done_q) begin
            state_q <= asq_pkg::ST_LOAD;
          end
        end
        asq_pkg::ST_LOAD: begin
          bit_cnt_q <= 4'h0;
          if (!data_ok) begin
            state_q  <= asq_pkg::ST_HOLD;
            scl_oe_q <= 1'b0;
          end else if (!byte_hi_q) begin
            sh_q      <= lo_q;
            sda_oe_q  <= ~lo_q[7];
            byte_hi_q <= 1'b1;
            scl_oe_q  <= 1'b0;
            state_q   <= asq_pkg::ST_TX;
          end else if (buf_cnt_q != 2'h0) begin
            sh_q      <= {`ASQ_FILLER, buf_head[11:8]};
            lo_q      <= buf_head[7:0];
            sda_oe_q  <= 1'b0;
            byte_hi_q <= 1'b0;
            scl_oe_q  <= 1'b0;
            state_q   <= asq_pkg::ST_TX;
          end
        end
        asq_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_q == 4'h7) begin
              sda_oe_q <= 1'b0;
              state_q  <= asq_pkg::ST_MACK;
            end else begin
              sh_q      <= {sh_q[6:0], 1'b0};
              sda_oe_q  <= ~sh_q[6];
              bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
            end
          end
        end
        asq_pkg::ST_MACK: begin
          if (scl_rise) begin
            ack_q <= ~sda_s2_q;
          end else if (scl_fall) begin
            if (ack_q) begin
              state_q  <= asq_pkg::ST_LOAD;
              scl_oe_q <= 1'b1;
            end else begin
              state_q <= asq_pkg::ST_HOLD;
            end
          end
        end
        asq_pkg::ST_HOLD: begin
          sda_oe_q <= 1'b0;
          scl_oe_q <= 1'b0;
        end
        default: begin
          sda_oe_q <= 1'b0;
          scl_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Power and reference control
  // ****************************************
  logic       pwr_d, pwr_q, keep_q, ref_on_q, ref_drv_q, zero_q, start_out_q;
  logic [2:0] sel, sel_prev_q;
  logic [1:0] ref_src_q;
  logic [3:0] ch_out_q;

  assign sel   = {REFERENCE_SOURCE_HIGH_BIT_IN, SHARED_PIN_REFERENCE_BIT_IN, INTERNAL_REFERENCE_KEEP_ON_BIT_IN};
  // Analog power follows conversions; internal readout runs with the analog side off
  assign pwr_d = (state_q == asq_pkg::ST_AACK) || (state_q == asq_pkg::ST_CONV) ||
                 (readout && ext_q);

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pwr_q       <= 1'b0;
      keep_q      <= 1'b0;
      sel_prev_q  <= 3'h0;
      ref_on_q    <= 1'b0;
      ref_drv_q   <= 1'b0;
      ref_src_q   <= `ASQ_REF_SUPPLY;
      zero_q      <= 1'b0;
      start_out_q <= 1'b0;
      ch_out_q    <= 4'h0;
    end else begin
      pwr_q       <= pwr_d;
      sel_prev_q  <= sel;
      start_out_q <= start_q;
      ch_out_q    <= ch_q;
      if (sel != sel_prev_q) begin
        keep_q <= 1'b0;
      end else if (pwr_d && sel[2] && sel[0]) begin
        keep_q <= 1'b1;
      end
      // With the keep-on bit set, the internal reference is kept out of shutdown after a conversion, for its long wake-up
      ref_on_q  <= sel[2] && (pwr_d || keep_q);
      ref_drv_q <= sel[2] && sel[1] && pwr_d;
      if (sel[2]) begin
        ref_src_q <= `ASQ_REF_INTERNAL;
      end else if (sel[1]) begin
        ref_src_q <= `ASQ_REF_EXTERNAL;
      end else begin
        ref_src_q <= `ASQ_REF_SUPPLY;
      end
    end
  end

  assign SCL_OUT        = zero_q;
  assign SDA_OUT        = zero_q;
  assign SCL_OE_OUT     = scl_oe_q;
  assign SDA_OE_OUT     = sda_oe_q;
  assign CONV_START_OUT = start_out_q;
  assign CONV_CH_OUT    = ch_out_q;
  assign ANALOG_PWR_OUT = pwr_q;
  assign REF_ON_OUT     = ref_on_q;
  assign REF_DRIVE_OUT  = ref_drv_q;
  assign REF_SRC_OUT    = ref_src_q;

endmodule

/* File: tb/asq_master.sv */
// Two-wire bus master model with pulled-up lines
`timescale 1ns/100ps
module asq_master (
  input  wire logic scl_oe_in,
  input  wire logic sda_oe_in,
  input  wire logic scl_val_in,
  input  wire logic sda_val_in,
  output logic      scl_out,
  output logic      sda_out
);
  logic c_q = 1'b1;
  logic d_q = 1'b1;
  // Pull-ups: a released line reads high; a driven line shows what the device puts out
  assign scl_out = c_q & (~scl_oe_in | scl_val_in);
  assign sda_out = d_q & (~sda_oe_in | sda_val_in);
  // 125 ns per bit; the wait honours stretching
  task automatic bit_x(input logic b, output logic r);
    #31.25 d_q = b;
    #31.25 c_q = 1'b1;
    wait (scl_out === 1'b1);
    #31.25 r = sda_out;
    #31.25 c_q = 1'b0;
  endtask
  // Start when p is 0, stop when p is 1
  task automatic cond_x(input logic p);
    #31.25 d_q = ~p;
    #31.25 c_q = 1'b1;
    #31.25 d_q = p;
    #31.25 c_q = p;
  endtask
  task automatic byte_x(input logic [7:0] w, input logic a, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) bit_x(i > 0 ? w[i-1] : a, r[i]);
  endtask
endmodule

/* File: tb/asq_top_asserts.sv */
// Port checker of the scan sequencer
`timescale 1ns/100ps
module asq_top_asserts (
  input wire logic       SYS_CLK_IN,
  input wire logic       RST_N_IN,
  input wire logic       SCL_OE_OUT,
  input wire logic       SCAN_MODE_HIGH_BIT_IN,
  input wire logic       SCAN_MODE_LOW_BIT_IN,
  input wire logic [3:0] CHANNEL_SELECT_FIELD_IN,
  input wire logic       EXT_CLOCK_MODE_IN,
  input wire logic       SHARED_PIN_REFERENCE_BIT_IN,
  input wire logic [1:0] VARIANT_IN,
  input wire logic       CONV_START_OUT,
  input wire logic [3:0] CONV_CH_OUT,
  input wire logic       ANALOG_PWR_OUT,
  input wire logic       REF_ON_OUT,
  input wire logic       REF_DRIVE_OUT,
  input wire logic [1:0] REF_SRC_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  property p_rs; $rose(RST_N_IN) |-> REF_SRC_OUT == 2'h0 && !ANALOG_PWR_OUT; endproperty
  a_rs: assert property (p_rs) else $error("reset state");
  property p_pw; CONV_START_OUT |=> ANALOG_PWR_OUT [*2]; endproperty
  a_pw: assert property (p_pw) else $error("power");
  property p_rv; CONV_START_OUT |-> CONV_CH_OUT <= 4'hb; endproperty
  a_rv: assert property (p_rv) else $error("channel");
  property p_on; CONV_START_OUT && SCAN_MODE_LOW_BIT_IN |-> CONV_CH_OUT ==
    (CHANNEL_SELECT_FIELD_IN & (VARIANT_IN[1] ? 4'hf : {1'b0, VARIANT_IN[0], 2'h3})); endproperty
  a_on: assert property (p_on) else $error("single");
  property p_up; CONV_START_OUT && SCAN_MODE_HIGH_BIT_IN && !SCAN_MODE_LOW_BIT_IN
    |-> CONV_CH_OUT >= (VARIANT_IN == 2'h0 ? 4'h2 : 4'h6); endproperty
  a_up: assert property (p_up) else $error("upper");
  property p_sh; CONV_START_OUT && SHARED_PIN_REFERENCE_BIT_IN && VARIANT_IN != 2'h1 && !SCAN_MODE_LOW_BIT_IN
    |-> CONV_CH_OUT != (VARIANT_IN == 2'h0 ? 4'h3 : 4'hb); endproperty
  a_sh: assert property (p_sh) else $error("shared");
  property p_dr; REF_DRIVE_OUT |-> REF_ON_OUT && ANALOG_PWR_OUT && REF_SRC_OUT == 2'h2; endproperty
  a_dr: assert property (p_dr) else $error("ref drive");
  property p_id; $fell(SCL_OE_OUT) && !EXT_CLOCK_MODE_IN |-> !ANALOG_PWR_OUT; endproperty
  a_id: assert property (p_id) else $error("idle");
endmodule
bind asq_top asq_top_asserts u_chk (.*);

/* File: tb/asq_top_bench.sv */
// Self-checking bench of the scan sequencer
`timescale 1ns/100ps
`include "asq_regs.svh"
module asq_top_bench;
  logic SYS_CLK_IN = 1'b0;
  logic RST_N_IN = 1'b0;
  logic SCAN_MODE_HIGH_BIT_IN, SCAN_MODE_LOW_BIT_IN, EXT_CLOCK_MODE_IN, REFERENCE_SOURCE_HIGH_BIT_IN;
  logic SHARED_PIN_REFERENCE_BIT_IN, INTERNAL_REFERENCE_KEEP_ON_BIT_IN, SCL_IN, SDA_IN, SCL_OUT, SDA_OUT;
  logic SCL_OE_OUT, SDA_OE_OUT, CONV_START_OUT, ANALOG_PWR_OUT, REF_ON_OUT, REF_DRIVE_OUT;
  logic [3:0] CHANNEL_SELECT_FIELD_IN, CONV_CH_OUT;
  logic [1:0] VARIANT_IN, REF_SRC_OUT;
  logic [11:0] ADC_RESULT_IN;
  logic [11:0] cfg = 12'h800;
  logic [7:0] salt = 8'h0;
  logic [8:0] r;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  // Each of the three internal reference selections in the table keeps it on, so no wake-up wait is needed
  logic [11:0] tbl [11] = '{12'h805, 12'h813, 12'h021, 12'h5e7, 12'h979, 12'hbf4,
                            12'ha02, 12'ha17, 12'h83d, 12'h083, 12'h8af};
  assign {VARIANT_IN, EXT_CLOCK_MODE_IN, REFERENCE_SOURCE_HIGH_BIT_IN, SHARED_PIN_REFERENCE_BIT_IN,
          INTERNAL_REFERENCE_KEEP_ON_BIT_IN, SCAN_MODE_HIGH_BIT_IN, SCAN_MODE_LOW_BIT_IN, CHANNEL_SELECT_FIELD_IN} = cfg;
  // Result carries its channel, so order errors show in the data
  assign ADC_RESULT_IN = {CONV_CH_OUT, salt};
  asq_top uut (.*);
  asq_master m (.scl_oe_in(SCL_OE_OUT), .sda_oe_in(SDA_OE_OUT), .scl_val_in(SCL_OUT), .sda_val_in(SDA_OUT),
                .scl_out(SCL_IN), .sda_out(SDA_IN));
  initial forever #2.5 SYS_CLK_IN = ~SYS_CLK_IN;
  function automatic int exp_ch(input int i);
    int s, mx, lo;
    s = cfg[3:0] & (cfg[11] ? 15 : cfg[10] ? 7 : 3);
    mx = cfg[11:10] == 2'h1 ? 7 : (cfg[11] ? 11 : 3) - cfg[7];
    lo = cfg[5] ? (cfg[11:10] == 2'h0 ? 2 : 6) : 0;
    mx = s < mx ? (s < lo ? lo : s) : mx;
    return cfg[4] ? s : lo + i % (mx - lo + 1);
  endfunction
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic results();
    if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic frame(input logic [11:0] c);
    logic rsv;
    @(posedge SYS_CLK_IN);
    #1 cfg = c;
    salt = 8'($urandom);
    rsv = c[11] && c[4] && c[3:0] > 4'hb;
    m.cond_x(1'b0);
    m.byte_x({`ASQ_SLAVE_ADDR, 1'b1}, 1'b1, r);
    cmp("ack", 8'h0, r[0]);
    for (int i = 0; i < 7; i++) begin
      m.byte_x(8'hff, 1'b0, r);
      cmp("msb", rsv ? 8'hff : {4'hf, 4'(exp_ch(i))}, r[8:1]);
      m.byte_x(8'hff, i == 6, r);
      cmp("lsb", rsv ? 8'hff : salt, r[8:1]);
    end
    m.byte_x(8'hff, 1'b1, r);
    cmp("released", 8'hff, r[8:1]);
    m.cond_x(1'b1);
    repeat (8) @(posedge SYS_CLK_IN);
    cmp("power", 8'h0, ANALOG_PWR_OUT);
    cmp("reference", {7'h0, c[8] && c[6]}, {6'h0, REF_DRIVE_OUT, REF_ON_OUT});
  endtask
  always @(posedge SYS_CLK_IN) begin
    cyc++;
    if (cyc == 95000) begin
      fails++;
      results();
    end
  end
  initial begin
    void'($urandom(32'h7694c5b1));
    repeat (8) @(posedge SYS_CLK_IN);
    #1 RST_N_IN = 1'b1;
    repeat (3) @(posedge SYS_CLK_IN);
    cmp("source", 8'h0, REF_SRC_OUT);
    foreach (tbl[k]) frame(tbl[k]);
    for (int a = 0; a < 2; a++) begin
      #1 m.cond_x(1'b0);
      m.byte_x({`ASQ_SLAVE_ADDR ^ {6'h0, a == 0}, a == 0}, 1'b1, r);
      cmp("no ack", 8'h1, r[0]);
      m.cond_x(1'b1);
    end
    results();
  end
endmodule
